// ---- src/pcirq_defines.svh ----
`ifndef PCIRQ_DEFINES_SVH
`define PCIRQ_DEFINES_SVH

// register byte addresses on the ahb-lite slave
`define ADDR_EXT_FLAGS 8'h00
`define ADDR_EXT_ENABLE 8'h04
`define ADDR_EXT_SENSE 8'h08
`define ADDR_PC_ENABLE 8'h0c
`define ADDR_PC_FLAGS 8'h10
`define ADDR_PC_MASK2 8'h14
`define ADDR_PC_MASK1 8'h18
`define ADDR_PC_MASK0 8'h1c
`define ADDR_STATUS 8'h20
`define ADDR_IRQ_MASK 8'h24
`define ADDR_ACK 8'h28
`define ADDR_GLOBAL 8'h2c

// field positions
`define EXT0_BIT 0
`define EXT1_BIT 1
`define GRP0_BIT 0
`define GRP1_BIT 1
`define GRP2_BIT 2
`define GRP1_VALID 8'h7f

// reset values
`define RESET_BYTE 8'h00
`define RESET_SENSE 4'h0

`endif

// ---- src/pcirq_pkg.sv ----
package pcirq_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DATA = 2'b01
    } bus_state_t;

endpackage : pcirq_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    // synchronised level and change pulse
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] changed
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [2:0] fill;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be at least one");
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.meta = pin_in;
        state_nxt.sync = state_r.meta;
        state_nxt.prev = state_r.sync;
        state_nxt.fill = {state_r.fill[1:0], 1'b1};
        if (srst) begin
            state_nxt = '0;
        end
    end

    always_ff @(posedge clock) begin
        state_r <= state_nxt;
    end

    assign level = state_r.sync;
    // no change until sync and prev both hold real samples, else a high idle
    // pin would look like an edge just after reset
    assign changed = state_r.fill[2] ? (state_r.sync ^ state_r.prev) : '0; // R19
endmodule : pin_sync

// ---- src/edge_sense.sv ----
`timescale 1ns/1ps
module edge_sense (
    // synchronised input
    input wire logic level,
    input wire logic changed,
    // sense field
    input wire logic [1:0] sense,
    // trigger event
    output logic trigger
);
    always_comb begin
        case (pcirq_pkg::sense_t'(sense))
            pcirq_pkg::SENSE_ANY: trigger = changed; // R18
            pcirq_pkg::SENSE_FALL: trigger = changed & ~level; // R18
            pcirq_pkg::SENSE_RISE: trigger = changed & level; // R18
            default: trigger = 1'b0;
        endcase
    end
endmodule : edge_sense

// ---- src/pin_change_ext_irq_flags.sv ----
// Behaviour
// (R01) edge on external input sets its flag
// (R02) set, enabled, global on: request external vector
// (R03) flags clear on vector ack or write one
// (R04) level-sensed external flag always held zero
// (R05) group 2 enable lets pins 16-23 interrupt
// (R06) group 1 enable lets pins 8-14 interrupt
// (R07) group 0 enable lets pins 0-7 interrupt
// (R08) change on pins 16-23 sets group 2 flag
// (R09) change in group 1 or 0 sets flag
// (R10) group flag, enabled, global on: request vector
// (R11) group 2 mask enables each pin 16-23
// (R12) group 1 mask bits 6..0, bit 7 zero
// (R13) group 0 mask enables each pin 0-7
// (R14) control and flag bits 7..3 read zero
// (R15) control and masks reset to zero
// (R16) pin changes detected without i/o clock; here the pins are sampled on the system clock
// (R17) pins trigger even when driven as outputs
// (R18) sense field: low, any, falling, rising
// (R19) synchronise pins, compare with previous sample
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pcirq_defines.svh"
module pin_change_ext_irq_flags #(
    parameter int GRP2_PINS = 8,
    parameter int GRP1_PINS = 7,
    parameter int GRP0_PINS = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins, sampled whatever their direction
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic [7:0] change_pins_0_to_7,
    input wire logic [6:0] change_pins_8_to_14,
    input wire logic [7:0] change_pins_16_to_23,
    // vector execution acknowledge from the cpu
    input wire logic [1:0] ext_vector_ack,
    input wire logic [2:0] group_vector_ack,
    // vector requests
    output logic [1:0] ext_vector_req,
    output logic group0_vector,
    output logic group1_vector,
    output logic group2_vector,
    // summary interrupt
    output logic irq
);
    typedef struct packed {
        pcirq_pkg::bus_state_t bus;
        logic [7:0] addr;
        logic wr;
        logic [31:0] rdata;
        logic [1:0] ext_flags;
        logic [1:0] ext_enable;
        logic [3:0] ext_sense;
        logic [2:0] pc_enable;
        logic [2:0] pc_flags;
        logic [7:0] mask2;
        logic [6:0] mask1;
        logic [7:0] mask0;
        logic [4:0] status;
        logic [4:0] irq_mask;
        logic global_en;
        logic [1:0] ext_req;
        logic [2:0] grp_req;
        logic irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [1:0] ext_level;
    logic [1:0] ext_changed;
    logic [1:0] ext_trig;
    logic [7:0] lvl0;
    logic [7:0] chg0;
    logic [6:0] lvl1;
    logic [6:0] chg1;
    logic [7:0] lvl2;
    logic [7:0] chg2;
    logic [2:0] grp_trig;
    logic [1:0] ext_level_mode;

    if (GRP2_PINS != 8 || GRP1_PINS != 7 || GRP0_PINS != 8) begin : g_bad_groups
        $error("pin group widths are fixed by the register layout");
    end

    // asynchronous wake detection is left to the power controller; here the
    // pins are sampled on the system clock
    pin_sync #(.WIDTH(2)) u_ext_sync (
        .clock(clock),
        .srst(srst),
        .pin_in({ext_irq1_input, ext_irq0_input}),
        .level(ext_level),
        .changed(ext_changed)
    );

    pin_sync #(.WIDTH(8)) u_grp0_sync (
        .clock(clock),
        .srst(srst),
        .pin_in(change_pins_0_to_7), // R16
        .level(lvl0),
        .changed(chg0)
    );

    pin_sync #(.WIDTH(7)) u_grp1_sync (
        .clock(clock),
        .srst(srst),
        .pin_in(change_pins_8_to_14),
        .level(lvl1),
        .changed(chg1)
    );

    pin_sync #(.WIDTH(8)) u_grp2_sync (
        .clock(clock),
        .srst(srst),
        .pin_in(change_pins_16_to_23),
        .level(lvl2),
        .changed(chg2)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            edge_sense u_sense (
                .level(ext_level[gi]),
                .changed(ext_changed[gi]),
                .sense(st_r.ext_sense[2*gi+1:2*gi]),
                .trigger(ext_trig[gi]) // R01 R17
            );
            assign ext_level_mode[gi] =
                (st_r.ext_sense[2*gi+1:2*gi] == pcirq_pkg::SENSE_LOW); // R04
        end
    endgenerate

    // masks gate detection per pin; flags are set regardless of the enable
    assign grp_trig[`GRP0_BIT] = |(chg0 & st_r.mask0); // R09 R13 R17
    assign grp_trig[`GRP1_BIT] = |(chg1 & st_r.mask1); // R09 R12
    assign grp_trig[`GRP2_BIT] = |(chg2 & st_r.mask2); // R08 R11

    function automatic logic [7:0] w1c_byte(input logic [31:0] d, input logic hit);
        w1c_byte = hit ? d[7:0] : 8'h00;
    endfunction : w1c_byte

    logic wr_go;
    logic rd_go;
    logic [1:0] ext_clr;
    logic [2:0] pc_clr;
    logic [4:0] stat_set;
    logic low_active0;
    logic low_active1;
    logic [7:0] ext_w1c;
    logic [7:0] pc_w1c;

    assign wr_go = (st_r.bus == pcirq_pkg::BUS_DATA) && st_r.wr;
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign ext_w1c = w1c_byte(hwdata, wr_go && st_r.addr == `ADDR_EXT_FLAGS);
    assign pc_w1c = w1c_byte(hwdata, wr_go && st_r.addr == `ADDR_PC_FLAGS);
    assign ext_clr = ext_vector_ack | ext_w1c[1:0]; // R03
    assign pc_clr = group_vector_ack | pc_w1c[2:0]; // R03
    assign stat_set = {grp_trig, ext_trig & ~ext_level_mode};
    assign low_active0 = ext_level_mode[0] && !ext_level[0];
    assign low_active1 = ext_level_mode[1] && !ext_level[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.bus = pcirq_pkg::BUS_IDLE;
        if (hsel && hready && htrans[1]) begin
            st_nxt.bus = pcirq_pkg::BUS_DATA;
            st_nxt.addr = haddr[7:0];
            st_nxt.wr = hwrite;
        end

        if (wr_go) begin
            case (st_r.addr)
                `ADDR_EXT_ENABLE: st_nxt.ext_enable = hwdata[1:0];
                `ADDR_EXT_SENSE: st_nxt.ext_sense = hwdata[3:0]; // R18
                `ADDR_PC_ENABLE: st_nxt.pc_enable = hwdata[2:0]; // R05 R06 R07
                `ADDR_PC_MASK2: st_nxt.mask2 = hwdata[7:0]; // R11
                `ADDR_PC_MASK1: st_nxt.mask1 = hwdata[6:0]; // R12
                `ADDR_PC_MASK0: st_nxt.mask0 = hwdata[7:0]; // R13
                `ADDR_IRQ_MASK: st_nxt.irq_mask = hwdata[4:0];
                `ADDR_GLOBAL: st_nxt.global_en = hwdata[0];
                default: st_nxt.global_en = st_r.global_en;
            endcase
        end

        // set wins over a clear arriving in the same cycle
        st_nxt.ext_flags = (st_r.ext_flags & ~ext_clr) | ext_trig; // R01 R03
        // use the sense being written, so a flag never outlives the switch to level
        for (int i = 0; i < 2; i++) begin
            if (st_nxt.ext_sense[2*i +: 2] == pcirq_pkg::SENSE_LOW) begin
                st_nxt.ext_flags[i] = 1'b0; // R04
            end
        end
        st_nxt.pc_flags = (st_r.pc_flags & ~pc_clr) | grp_trig; // R03 R08 R09

        // sticky status, cleared by reading it; new events still win
        st_nxt.rdata = 32'h0;
        if (rd_go) begin
            case (haddr[7:0])
                `ADDR_EXT_FLAGS: st_nxt.rdata = {30'h0, st_r.ext_flags};
                `ADDR_EXT_ENABLE: st_nxt.rdata = {30'h0, st_r.ext_enable};
                `ADDR_EXT_SENSE: st_nxt.rdata = {28'h0, st_r.ext_sense};
                `ADDR_PC_ENABLE: st_nxt.rdata = {29'h0, st_r.pc_enable}; // R14
                `ADDR_PC_FLAGS: st_nxt.rdata = {29'h0, st_r.pc_flags}; // R14
                `ADDR_PC_MASK2: st_nxt.rdata = {24'h0, st_r.mask2};
                `ADDR_PC_MASK1: st_nxt.rdata = {25'h0, st_r.mask1}; // R12
                `ADDR_PC_MASK0: st_nxt.rdata = {24'h0, st_r.mask0};
                `ADDR_STATUS: st_nxt.rdata = {27'h0, st_r.status};
                `ADDR_IRQ_MASK: st_nxt.rdata = {27'h0, st_r.irq_mask};
                `ADDR_GLOBAL: st_nxt.rdata = {31'h0, st_r.global_en};
                default: st_nxt.rdata = 32'h0;
            endcase
        end
        if (rd_go && haddr[7:0] == `ADDR_STATUS) begin
            st_nxt.status = stat_set;
        end else begin
            st_nxt.status = st_r.status | stat_set;
        end

        // low level requests directly while the pin stays low
        st_nxt.ext_req[0] = st_r.global_en && st_r.ext_enable[0]
            && (st_r.ext_flags[0] || low_active0); // R02
        st_nxt.ext_req[1] = st_r.global_en && st_r.ext_enable[1]
            && (st_r.ext_flags[1] || low_active1); // R02
        st_nxt.grp_req = {3{st_r.global_en}} & st_r.pc_enable & st_r.pc_flags; // R10 R05 R06 R07
        st_nxt.irq = |(st_nxt.status & st_r.irq_mask);

        if (srst) begin
            st_nxt = '0; // R15
            st_nxt.ext_sense = `RESET_SENSE;
            st_nxt.mask0 = `RESET_BYTE;
            st_nxt.mask2 = `RESET_BYTE;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // a pin change during sleep without a clock is caught on wake by the
    // synchroniser only if the level persists; true async wake lives upstream
    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ext_vector_req = st_r.ext_req;
    assign group0_vector = st_r.grp_req[`GRP0_BIT];
    assign group1_vector = st_r.grp_req[`GRP1_BIT];
    assign group2_vector = st_r.grp_req[`GRP2_BIT];
    assign irq = st_r.irq;
endmodule : pin_change_ext_irq_flags

// ---- dv/pcirq_assertions.sv ----
`timescale 1ns/1ps
module pcirq_checker (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // pins and vectors
    input wire logic [7:0] change_pins_0_to_7,
    input wire logic [6:0] change_pins_8_to_14,
    input wire logic [7:0] change_pins_16_to_23,
    input wire logic [2:0] group_vector_ack,
    input wire logic [1:0] ext_vector_req,
    input wire logic group0_vector,
    input wire logic group1_vector,
    input wire logic group2_vector
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic dp_r, dw_r, gl_r;
    logic [7:0] da_r;
    logic [1:0] xen_r;
    logic [3:0] sen_r;
    logic [2:0] pcen_r, quiet_r;
    logic [22:0] pins_r;
    wire logic [22:0] pins = {change_pins_16_to_23, change_pins_8_to_14, change_pins_0_to_7};
    wire logic rd = dp_r && !dw_r;
    wire logic wr = dp_r && dw_r;
    // shadows commit at the same edge as the slave, so $past lines up with the request flop
    always_ff @(posedge clock) begin
        pins_r <= pins;
        dw_r <= hwrite;
        da_r <= haddr[7:0];
        if (srst) begin
            {dp_r, gl_r, xen_r, sen_r, pcen_r, quiet_r} <= '0;
        end else begin
            dp_r <= hsel && hready && htrans[1];
            quiet_r <= (pins != pins_r) ? 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
            if (wr && da_r == 8'h04) xen_r <= hwdata[1:0];
            if (wr && da_r == 8'h08) sen_r <= hwdata[3:0];
            if (wr && da_r == 8'h0c) pcen_r <= hwdata[2:0];
            if (wr && da_r == 8'h2c) gl_r <= hwdata[0];
        end
    end
    property p_ext0_gate;
        ext_vector_req[0] |-> $past(gl_r && xen_r[0]);
    endproperty
    a_ext0_gate: assert property (p_ext0_gate) else $error("ext0 request while gated");
    property p_grp0_gate;
        group0_vector |-> $past(gl_r && pcen_r[0]);
    endproperty
    a_grp0_gate: assert property (p_grp0_gate) else $error("group0 vector while gated");
    property p_grp1_gate;
        group1_vector |-> $past(gl_r && pcen_r[1]);
    endproperty
    a_grp1_gate: assert property (p_grp1_gate) else $error("group1 vector while gated");
    property p_grp2_gate;
        group2_vector |-> $past(gl_r) && $past(pcen_r[2]);
    endproperty
    a_grp2_gate: assert property (p_grp2_gate) else $error("group2 vector while gated");
    property p_ack_clear;
        group_vector_ack[0] && quiet_r == 3'h7 |-> ##2 !group0_vector;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("vector ack left group0");
    property p_w1c_clear;
        wr && da_r == 8'h10 && hwdata[1] && quiet_r == 3'h7 |-> ##2 !group1_vector;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("write one left group1");
    property p_level_zero;
        (sen_r[1:0] == 2'h0) [*4] ##0 (rd && da_r == 8'h00) |-> !hrdata[0];
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("level mode flag set");
    property p_ctl_rsvd;
        rd && (da_r == 8'h0c || da_r == 8'h10) |-> hrdata[31:3] == 29'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bits not zero");
    property p_mask1_rsvd;
        rd && da_r == 8'h18 |-> hrdata[31:7] == 25'h0;
    endproperty
    a_mask1_rsvd: assert property (p_mask1_rsvd) else $error("mask1 bit 7 not zero");
endmodule : pcirq_checker

bind pin_change_ext_irq_flags pcirq_checker i_chk (
    .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .change_pins_0_to_7, .change_pins_8_to_14, .change_pins_16_to_23,
    .group_vector_ack, .ext_vector_req, .group0_vector, .group1_vector, .group2_vector
);

// ---- dv/cpu_vector_model.sv ----
`timescale 1ns/1ps
module cpu_vector_model (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // behaviour
    input wire logic ack_en,
    input wire logic [3:0] delay,
    // vector handshake
    input wire logic [1:0] ext_vector_req,
    input wire logic group0_vector,
    input wire logic group1_vector,
    input wire logic group2_vector,
    output logic [1:0] ext_vector_ack,
    output logic [2:0] group_vector_ack
);
    logic [4:0] ack_r = 5'h0;
    logic [4:0] cnt_r = 5'h0;
    wire logic [4:0] req = {group2_vector, group1_vector, group0_vector, ext_vector_req};
    assign ext_vector_ack = ack_r[1:0];
    assign group_vector_ack = ack_r[4:2];
    // one vector at a time, lowest first; the gap lets the served request fall
    always @(posedge clock) begin
        ack_r <= 5'h0;
        if (srst || !ack_en || req == 5'h0) begin
            cnt_r <= 5'h0;
        end else if (cnt_r == {1'b0, delay} + 5'h3) begin
            cnt_r <= 5'h0;
        end else begin
            cnt_r <= cnt_r + 5'h1;
            if (cnt_r == {1'b0, delay}) ack_r <= req & (~req + 5'h1);
        end
    end
endmodule : cpu_vector_model

// ---- dv/pin_change_ext_irq_flags_test.sv ----
`timescale 1ns/1ps
module pin_change_ext_irq_flags_test;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b1, hwrite = 1'b0, ack_en = 1'b0;
    logic ext_irq0_input = 1'b1, ext_irq1_input = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] delay = 4'h1;
    logic [7:0] change_pins_0_to_7 = 8'h0, change_pins_16_to_23 = 8'h0;
    logic [6:0] change_pins_8_to_14 = 7'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] ext_vector_ack, ext_vector_req;
    logic [2:0] group_vector_ack;
    logic hreadyout, hresp, group0_vector, group1_vector, group2_vector, irq;
    wire logic [2:0] vec = {group2_vector, group1_vector, group0_vector};
    int n_fail = 0;
    int compares = 0;
    row_t rows [11] = '{'{8'h00, 32'hff, 32'h0}, '{8'h04, 32'hff, 32'h3},
        '{8'h08, 32'hff, 32'hf}, '{8'h0c, 32'hff, 32'h7}, '{8'h10, 32'hff, 32'h0},
        '{8'h14, 32'hff, 32'hff}, '{8'h18, 32'hff, 32'h7f}, '{8'h1c, 32'hff, 32'hff},
        '{8'h24, 32'hff, 32'h1f}, '{8'h2c, 32'hff, 32'h1}, '{8'h30, 32'hff, 32'h0}};
    pin_change_ext_irq_flags i_dut (
        .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .ext_irq0_input, .ext_irq1_input, .change_pins_0_to_7, .change_pins_8_to_14,
        .change_pins_16_to_23, .ext_vector_ack, .group_vector_ack, .ext_vector_req,
        .group0_vector, .group1_vector, .group2_vector, .irq
    );
    cpu_vector_model i_cpu (
        .clock, .srst, .ack_en, .delay, .ext_vector_req, .group0_vector,
        .group1_vector, .group2_vector, .ext_vector_ack, .group_vector_ack
    );
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // seven edges covers synchroniser, flag and request flops with a margin
    task automatic flip(input int g, input int b);
        case (g)
            0: change_pins_0_to_7[b] <= ~change_pins_0_to_7[b];
            1: change_pins_8_to_14[b] <= ~change_pins_8_to_14[b];
            default: change_pins_16_to_23[b] <= ~change_pins_16_to_23[b];
        endcase
        repeat (7) @(posedge clock);
    endtask : flip
    task automatic ext_pin(input int i, input logic v);
        if (i == 0) ext_irq0_input <= v;
        else ext_irq1_input <= v;
        repeat (7) @(posedge clock);
    endtask : ext_pin
    task automatic reset_check();
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'({vec, ext_vector_req, irq}), 32'h0);
        for (int a = 0; a < 48; a += 4) begin
            rd(8'(a));
            chk(q | 32'(hresp), 32'h0);
        end
    endtask : reset_check
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_of_test();
    end
    initial begin
        reset_check();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(q, rows[i].e);
        end
        for (int g = 0; g < 3; g++) begin
            flip(g, 6);
            chk(32'(vec), 32'(1 << g));
            rd(8'h10);
            chk(q, 32'(1 << g));
            wr(8'h10, 32'(1 << g));
            rd(8'h10);
            chk(q | 32'(vec), 32'h0);
        end
        for (int g = 0; g < 3; g++) begin
            wr(8'h1c - 8'(4 * g), 32'h0);
            flip(g, 3);
            rd(8'h10);
            chk(q, 32'h0);
        end
        wr(8'h1c, 32'hff);
        wr(8'h0c, 32'h0);
        flip(0, 1);
        rd(8'h10);
        chk(q | 32'(vec), 32'h1);
        wr(8'h0c, 32'h1);
        repeat (2) @(posedge clock);
        chk(32'(vec), 32'h1);
        wr(8'h2c, 32'h0);
        repeat (2) @(posedge clock);
        chk(32'(vec), 32'h0);
        wr(8'h2c, 32'h1);
        wr(8'h10, 32'h1);
        for (int i = 0; i < 2; i++) begin
            for (int m = 0; m < 4; m++) begin
                wr(8'h08, 32'(m << (2 * i)));
                ext_pin(i, 1'b0);
                rd(8'h00);
                chk(q, 32'(m == 1 || m == 2) << i);
                chk(32'(ext_vector_req), 32'(m != 3) << i);
                wr(8'h00, 32'h3);
                ext_pin(i, 1'b1);
                rd(8'h00);
                chk(q, 32'(m == 1 || m == 3) << i);
                wr(8'h00, 32'h3);
            end
        end
        // a flag caught in change mode must vanish once level mode is chosen
        wr(8'h08, 32'h1);
        ext_pin(0, 1'b0);
        rd(8'h00);
        chk(q, 32'h1);
        wr(8'h08, 32'h0);
        rd(8'h00);
        chk(q, 32'h0);
        ext_pin(0, 1'b1);
        rd(8'h20);
        wr(8'h24, 32'h4);
        flip(0, 2);
        chk(32'(irq), 32'h1);
        rd(8'h20);
        chk(q, 32'h4);
        rd(8'h20);
        chk(q | 32'(irq), 32'h0);
        wr(8'h24, 32'h0);
        flip(0, 2);
        chk(32'(irq), 32'h0);
        wr(8'h10, 32'h1);
        ack_en <= 1'b1;
        for (int j = 1; j < 12; j += 8) begin
            delay <= 4'(j);
            flip(0, 4);
            repeat (j + 6) @(posedge clock);
            rd(8'h10);
            chk(q | 32'(vec), 32'h0);
        end
        ack_en <= 1'b0;
        reset_check();
        end_of_test();
    end
endmodule : pin_change_ext_irq_flags_test
